// >>> hw/cfg_mgmt_cfg.svh
// Constants for the configuration management port: address fields, timing and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CFG_MGMT_CFG_SVH
`define CFG_MGMT_CFG_SVH
`define CM_ADDR_W        19
`define CM_DATA_W        32
`define CM_BE_W          4
`define CM_SPACE_BIT     18
`define CM_FUNC_HI       17
`define CM_FUNC_LO       10
`define CM_REG_HI        9
`define CM_REG_LO        0
`define CM_FUNC_W        8
`define CM_REG_W         10
`define CM_NUM_FUNC      2
`define CM_NUM_CFG_REGS  64
`define CM_NUM_MGMT_REGS 16
`define CM_TYPE1_LO      4
`define CM_TYPE1_HI      15
`define CM_RO_MASK       32'h0000FFFF
`define CM_ACCESS_LAT    2
`define CM_DATA_RST      32'h00000000
`endif

// >>> hw/cfg_mgmt_pkg.sv
// Types shared by both ends of the configuration management port.
// Assumes the constant header is on the include path.
`include "cfg_mgmt_cfg.svh"
package cfg_mgmt_pkg;
   typedef logic [`CM_ADDR_W-1:0] cm_addr_t;
   typedef logic [`CM_DATA_W-1:0] cm_data_t;
   typedef logic [`CM_BE_W-1:0]   cm_be_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_DONE = 3'b100
   } cm_state_t;
endpackage : cfg_mgmt_pkg

// >>> hw/cfg_mgmt_if.sv
// Interface joining the user requester and the configuration space port.
// Assumes both ends share one clock; the bench instantiates it.
interface cfg_mgmt_if;
   import cfg_mgmt_pkg::*;
   cm_addr_t addr;
   logic     write;
   cm_data_t write_data;
   cm_be_t   byte_enable;
   logic     read;
   cm_data_t read_data;
   logic     read_write_done;
   logic     type1_readonly_override;
   modport device (
      input  addr, write, write_data, byte_enable, read, type1_readonly_override,
      output read_data, read_write_done
   );
   modport requester (
      output addr, write, write_data, byte_enable, read, type1_readonly_override,
      input  read_data, read_write_done
   );
endinterface : cfg_mgmt_if

// >>> hw/cfg_mgmt_device.sv
// Configuration space end: holds per-function config registers and local management registers.
// Assumes the requester keeps its request stable until the completion pulse.
// Summary of operation
// R1 - 19-bit dword address selects every access
// R2 - Bits 17:10 choose the owning function
// R3 - Bits 9:0 choose register within function
// R4 - Bit 18 low config, high management
// R5 - Requester raises write strobe to write
// R6 - Write data updates the addressed register
// R7 - Byte enable bit n guards byte n
// R8 - Requester raises read strobe to read
// R9 - Read returns addressed register's full word
// R10 - Completion pulses high for exactly one cycle
// R11 - Root Port override writes Type-1 read-only fields
// R12 - Override ignored for Endpoint or other registers
// R13 - Requester holds request; never both strobes
`include "cfg_mgmt_cfg.svh"

module cfg_mgmt_device #(
   parameter int NUM_FUNC  = `CM_NUM_FUNC,
   parameter int NUM_REGS  = `CM_NUM_CFG_REGS,
   parameter int NUM_MGMT  = `CM_NUM_MGMT_REGS,
   parameter int LATENCY   = `CM_ACCESS_LAT
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Mode strap: high selects Root Port behaviour
   input  wire logic root_port_mode,
   // Port towards the requester
   cfg_mgmt_if.device port
);
   import cfg_mgmt_pkg::*;

   // Index widths into the local arrays; a single entry still needs one index bit.
   localparam int FUNC_IW = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1;
   localparam int REG_IW  = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;
   localparam int MGMT_IW = (NUM_MGMT > 1) ? $clog2(NUM_MGMT) : 1;
   // The wait counter must hold LATENCY, the value it reaches on leaving the busy stretch.
   localparam int WAIT_W  = $clog2(LATENCY + 1);

   // One bank of configuration words per function, and one bank of management words.
   cm_data_t               cfg_mem [NUM_FUNC][NUM_REGS];
   cm_data_t               mgmt_mem [NUM_MGMT];
   cm_state_t              state_r;
   logic [WAIT_W-1:0]      wait_r;
   cm_data_t               read_data_r;
   logic                   done_r;
   logic                   last_beat;
   logic                   commit_wr;
   logic                   is_mgmt;
   logic [`CM_FUNC_W-1:0]  func_sel;
   logic [`CM_REG_W-1:0]   reg_sel;
   logic [FUNC_IW-1:0]     func_idx;
   logic [REG_IW-1:0]      reg_idx;
   logic [MGMT_IW-1:0]     mgmt_idx;
   logic                   hit;
   logic                   override;
   cm_data_t               cur;
   cm_data_t               wr_mask;
   cm_data_t               merged;

   // Merge a write into the old word under byte enables and a writable-bit mask.
   function automatic cm_data_t merge_bytes(input cm_data_t old_v, input cm_data_t new_v,
                                            input cm_be_t be, input cm_data_t bit_mask);
      cm_data_t res;
      res = old_v;
      for (int b = 0; b < `CM_BE_W; b++) begin
         for (int i = 0; i < 8; i++) begin
            if (be[b] && bit_mask[b*8+i]) begin // R7
               res[b*8+i] = new_v[b*8+i];
            end
         end
      end
      return res;
   endfunction : merge_bytes

   // Management space ignores the function bits, so only the register index is checked there.
   function automatic logic addr_hit(input logic mgmt, input logic [`CM_FUNC_W-1:0] fn,
                                     input logic [`CM_REG_W-1:0] idx);
      logic res;
      if (mgmt) begin
         res = 32'(idx) < NUM_MGMT;
      end else begin
         res = (32'(fn) < NUM_FUNC) && (32'(idx) < NUM_REGS);
      end
      return res;
   endfunction : addr_hit

   // Type-1 header registers are the only ones whose read-only fields can be overridden.
   function automatic logic is_type1_reg(input logic [`CM_REG_W-1:0] idx);
      return (32'(idx) >= `CM_TYPE1_LO) && (32'(idx) <= `CM_TYPE1_HI);
   endfunction : is_type1_reg

   // Last busy cycle: the access commits and the completion pulse is launched.
   function automatic logic is_last_beat(input cm_state_t st, input logic [WAIT_W-1:0] cnt);
      return (st == ST_BUSY) && (32'(cnt) >= LATENCY - 1);
   endfunction : is_last_beat

   assign is_mgmt   = port.addr[`CM_SPACE_BIT];                           // R4
   assign func_sel  = port.addr[`CM_FUNC_HI:`CM_FUNC_LO];                 // R1 R2
   assign reg_sel   = port.addr[`CM_REG_HI:`CM_REG_LO];                   // R3
   assign func_idx  = func_sel[FUNC_IW-1:0];
   assign reg_idx   = reg_sel[REG_IW-1:0];
   assign mgmt_idx  = reg_sel[MGMT_IW-1:0];
   // Unmapped functions or registers read as zero and swallow writes, but still complete.
   assign hit       = addr_hit(is_mgmt, func_sel, reg_sel);
   assign last_beat = is_last_beat(state_r, wait_r);
   // Address, data and enables are sampled live at the last beat rather than latched at take;
   // this saves a request register but relies on the requester holding them until completion.
   assign commit_wr = last_beat && port.write && hit;                     // R5 R6

   always_comb begin
      cur = `CM_DATA_RST;
      if (hit && is_mgmt) begin
         cur = mgmt_mem[mgmt_idx];
      end else if (hit) begin
         cur = cfg_mem[func_idx][reg_idx];
      end
   end

   // The override only reaches Type-1 header registers, and only in Root Port mode;
   // an Endpoint drops it entirely.
   assign override = root_port_mode && !is_mgmt && port.type1_readonly_override
                     && is_type1_reg(reg_sel);                            // R11 R12
   // Management registers have no read-only fields.
   assign wr_mask  = (override || is_mgmt) ? 32'hFFFFFFFF : ~`CM_RO_MASK;
   assign merged   = merge_bytes(cur, port.write_data, port.byte_enable, wr_mask);

   // Access sequencer: idle, a fixed busy stretch, then one completion cycle.
   // Strobes are not looked at again until the sequencer is back in idle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (port.write || port.read) begin                         // R5 R8
                  state_r <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (last_beat) begin
                  state_r <= ST_DONE;
               end
            end
            // Spend the pulse cycle here so a held strobe is not taken twice.
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Wait counter: cleared outside the busy stretch, counting through it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= '0;
      end else if (state_r == ST_BUSY) begin
         wait_r <= wait_r + WAIT_W'(1);
      end else begin
         wait_r <= '0;
      end
   end

   // Resetting the arrays costs a reset on every word, but without it read-only fields
   // would stay unknown for ever, since only the override can write them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int f = 0; f < NUM_FUNC; f++) begin
            for (int r = 0; r < NUM_REGS; r++) begin
               cfg_mem[FUNC_IW'(f)][REG_IW'(r)] <= `CM_DATA_RST;
            end
         end
         for (int m = 0; m < NUM_MGMT; m++) begin
            mgmt_mem[MGMT_IW'(m)] <= `CM_DATA_RST;
         end
      end else if (commit_wr && is_mgmt) begin
         mgmt_mem[mgmt_idx] <= merged;                                    // R6
      end else if (commit_wr) begin
         cfg_mem[func_idx][reg_idx] <= merged;                            // R6
      end
   end

   // The pulse is launched from the single last busy cycle, so it lasts exactly one clock.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= 1'b0;
      end else begin
         done_r <= last_beat;                                             // R10
      end
   end

   // Read data is held until the next read completes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_data_r <= `CM_DATA_RST;
      end else if (last_beat && port.read) begin
         read_data_r <= cur;                                              // R8 R9
      end
   end

   assign port.read_data       = read_data_r;
   assign port.read_write_done = done_r;
endmodule : cfg_mgmt_device

// >>> hw/cfg_mgmt_requester.sv
// User-side requester: turns one-cycle commands into held strobes on the port.
// Assumes the device answers every access with one completion pulse.
`include "cfg_mgmt_cfg.svh"

module cfg_mgmt_requester (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // User command, taken when idle
   input  wire logic                 cmd_valid,
   input  wire logic                 cmd_write,
   input  wire cfg_mgmt_pkg::cm_addr_t cmd_addr,
   input  wire cfg_mgmt_pkg::cm_data_t cmd_data,
   input  wire cfg_mgmt_pkg::cm_be_t   cmd_be,
   input  wire logic                 cmd_override,
   // User status
   output logic                      busy,
   output logic                      rsp_valid,
   output cfg_mgmt_pkg::cm_data_t    rsp_data,
   // Port towards the device
   cfg_mgmt_if.requester             port
);
   import cfg_mgmt_pkg::*;

   cm_addr_t addr_r;
   cm_data_t wdata_r;
   cm_be_t   be_r;
   logic     wr_r;
   logic     rd_r;
   logic     ovr_r;
   logic     busy_r;
   logic     rsp_valid_r;
   cm_data_t rsp_data_r;

   // Request held stable until completion; write and read never together.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r  <= '0;
         wdata_r <= `CM_DATA_RST;
         be_r    <= '0;
         wr_r    <= 1'b0;
         rd_r    <= 1'b0;
         ovr_r   <= 1'b0;
         busy_r  <= 1'b0;
      end else if (!busy_r && cmd_valid) begin
         addr_r  <= cmd_addr;                 // R1 R4
         wdata_r <= cmd_data;
         be_r    <= cmd_be;                   // R7
         wr_r    <= cmd_write;                // R5
         rd_r    <= !cmd_write;               // R8 R13
         ovr_r   <= cmd_override;
         busy_r  <= 1'b1;
      end else if (busy_r && port.read_write_done) begin
         wr_r   <= 1'b0;                      // R13
         rd_r   <= 1'b0;
         ovr_r  <= 1'b0;
         busy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= `CM_DATA_RST;
      end else begin
         rsp_valid_r <= busy_r && port.read_write_done;
         if (busy_r && port.read_write_done && rd_r) begin
            rsp_data_r <= port.read_data;
         end
      end
   end

   assign port.addr                    = addr_r;
   assign port.write                   = wr_r;
   assign port.write_data              = wdata_r;
   assign port.byte_enable             = be_r;
   assign port.read                    = rd_r;
   assign port.type1_readonly_override = ovr_r;
   assign busy      = busy_r;
   assign rsp_valid = rsp_valid_r;
   assign rsp_data  = rsp_data_r;
endmodule : cfg_mgmt_requester

// >>> verif/cfg_mgmt_monitor.sv
// Checker for the configuration management port, watching the interface signals.
// Assumes one clock domain and instantiation beside the interface in the bench.
module cfg_mgmt_monitor (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rst_n,
   // Interface signals
   input wire cfg_mgmt_pkg::cm_addr_t addr,
   input wire logic                   write,
   input wire cfg_mgmt_pkg::cm_data_t write_data,
   input wire cfg_mgmt_pkg::cm_be_t   byte_enable,
   input wire logic                   read,
   input wire cfg_mgmt_pkg::cm_data_t read_data,
   input wire logic                   read_write_done,
   input wire logic                   type1_readonly_override
);
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_mgmt_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      $rose(read || write);
   endsequence
   sequence s_quiet;
      !read_write_done [*2];
   endsequence
   property p_latency; s_take |=> s_quiet ##1 read_write_done; endproperty
   property p_wait; (read || write) && !read_write_done |-> ##[0:3] read_write_done; endproperty
   property p_pulse; read_write_done |=> !read_write_done; endproperty
   property p_cause; read_write_done |-> (read ^ write); endproperty
   property p_excl; !(read && write); endproperty
   property p_hold;
      (read || write) && !read_write_done |=> (read || write) && $stable(addr) && $stable(write_data)
         && $stable(byte_enable);
   endproperty
   property p_release; read_write_done |=> !(read || write); endproperty
   property p_rdata; $changed(read_data) |-> read_write_done && read; endproperty
   a_latency: assert property (p_latency) else $error("Completion not three cycles after take.");
   a_wait: assert property (p_wait) else $error("Pending access not completed in time.");
   a_pulse: assert property (p_pulse) else $error("Completion longer than one cycle.");
   a_cause: assert property (p_cause) else $error("Completion without a single strobe.");
   a_excl: assert property (p_excl) else $error("Read and write strobes together.");
   a_hold: assert property (p_hold) else $error("Request changed before completion.");
   a_release: assert property (p_release) else $error("Strobe held after completion.");
   a_rdata: assert property (p_rdata) else $error("Read data moved outside a read completion.");
endmodule : cfg_mgmt_monitor

// >>> verif/config_space_mgmt_port_tb.sv
// Self-checking bench: requester and device joined by the interface, driven by user commands.
// Assumes the requester paces commands by busy and reports every completion on rsp_valid.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module config_space_mgmt_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_mgmt_pkg::*;
   logic     clk = 1'h0;
   logic     rst_n = 1'h0;
   logic     root_mode = 1'h1;
   logic     cmd_valid = 1'h0;
   logic     cmd_write = 1'h0;
   logic     cmd_override = 1'h0;
   cm_addr_t cmd_addr = 19'h00000;
   cm_data_t cmd_data = 32'h00000000;
   cm_be_t   cmd_be = 4'h0;
   logic     busy;
   logic     rsp_valid;
   cm_data_t rsp_data;
   cm_data_t got;
   int       mismatches = 0;
   int       samples_checked = 0;
   int       cycles = 0;
   cfg_mgmt_if bus ();
   cfg_mgmt_device i_cfg_mgmt_device (.clk(clk), .rst_n(rst_n), .root_port_mode(root_mode), .port(bus.device));
   cfg_mgmt_requester i_cfg_mgmt_requester (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_be(cmd_be),
      .cmd_override(cmd_override), .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .port(bus.requester));
   cfg_mgmt_monitor i_cfg_mgmt_monitor (.clk(clk), .rst_n(rst_n), .addr(bus.addr), .write(bus.write),
      .write_data(bus.write_data), .byte_enable(bus.byte_enable), .read(bus.read),
      .read_data(bus.read_data), .read_write_done(bus.read_write_done),
      .type1_readonly_override(bus.type1_readonly_override));
   always #10 clk = ~clk;
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   // The wire is checked in the completion cycle, when the request must still be held.
   task automatic acc(input logic w, input cm_addr_t a, input cm_data_t d, input cm_be_t b, input logic o);
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (busy !== 1'h0) @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_be <= b;
      cmd_override <= o;
      @(posedge clk);
      cmd_valid <= 1'h0;
      while (rsp_valid !== 1'h1 && n < 40) begin
         @(negedge clk);
         n++;
         if (bus.read_write_done === 1'h1) begin
            `CHK(bus.addr, a)
            `CHK({bus.write, bus.read}, {w, ~w})
            if (w) `CHK(bus.byte_enable, b)
            if (w) `CHK(bus.write_data, d)
            `CHK(bus.type1_readonly_override, o)
         end
      end
      if (n >= 40) mismatches++;
      got = rsp_data;
   endtask : acc
   task automatic rd(input cm_addr_t a, input cm_data_t e);
      acc(1'h0, a, 32'h00000000, 4'h0, 1'h0);
      `CHK(got, e)
   endtask : rd
   // The ceiling is about five times the roughly two hundred cycles the sequence needs.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      acc(1'h1, 19'h40003, 32'h11223344, 4'hF, 1'h0);
      rd(19'h40003, 32'h11223344);
      acc(1'h1, 19'h40003, 32'hAABBCCDD, 4'h5, 1'h0);
      rd(19'h40003, 32'h11BB33DD);
      acc(1'h1, 19'h40003, 32'hFFFFFFFF, 4'h0, 1'h0);
      rd(19'h40403, 32'h11BB33DD);
      acc(1'h1, 19'h00005, 32'hCAFE1234, 4'hF, 1'h1);
      acc(1'h1, 19'h00405, 32'h0BAD5678, 4'hF, 1'h1);
      rd(19'h00005, 32'hCAFE1234);
      rd(19'h00405, 32'h0BAD5678);
      acc(1'h1, 19'h00005, 32'h55559999, 4'hF, 1'h0);
      rd(19'h00005, 32'h55551234);
      acc(1'h1, 19'h00004, 32'h89ABCDEF, 4'hF, 1'h1);
      rd(19'h00004, 32'h89ABCDEF);
      acc(1'h1, 19'h00003, 32'h12345678, 4'hF, 1'h1);
      rd(19'h00003, 32'h12340000);
      acc(1'h1, 19'h00010, 32'h3C3C5A5A, 4'hF, 1'h1);
      rd(19'h00010, 32'h3C3C0000);
      @(posedge clk);
      root_mode <= 1'h0;
      acc(1'h1, 19'h00005, 32'h7777AAAA, 4'hF, 1'h1);
      rd(19'h00005, 32'h77771234);
      rd(19'h00805, 32'h00000000);
      rd(19'h00040, 32'h00000000);
      acc(1'h1, 19'h40010, 32'h5A5AA5A5, 4'hF, 1'h0);
      rd(19'h40010, 32'h00000000);
      rd(19'h4000F, 32'h00000000);
      conclude();
   end
endmodule : config_space_mgmt_port_tb
